// [rtl/gripper_modbus_command_sequencer.sv]
// Purpose: Modbus RTU slave that takes gripper commands and reports activation state
// Assumes: rx_frame_end pulses once after the inter-frame silence, never before the last byte
// Notes:   Only function 3 on the status word and function 16 on the command words answer
`timescale 1ns/10ps
module gripper_modbus_command_sequencer
	import gripper_pkg::*;
(
	// Clock and reset
	input  wire logic        sys_clk,
	input  wire logic        rst,
	// Received bytes
	input  wire logic        rx_valid,
	input  wire logic [7:0]  rx_data,
	input  wire logic        rx_frame_end,
	// Transmitted bytes
	output logic      [7:0]  tx_data,
	output logic             tx_valid,
	input  wire logic        tx_ready,
	// Mechanism side
	input  wire logic        activation_complete,
	output logic             activate_request_bit,
	output logic             goto_request_bit,
	output logic      [7:0]  target_position_value,
	output logic      [7:0]  speed_value,
	output logic      [7:0]  force_value,
	output logic             frame_error
);

	seq_state_t  state_reg;
	logic [7:0]  rx_buf [RX_DEPTH];
	logic [7:0]  tx_buf [TX_DEPTH];
	logic [4:0]  rx_count_reg;
	logic        rx_overflow_reg;
	logic [3:0]  tx_len_reg;
	logic [3:0]  tx_idx_reg;
	logic [7:0]  tx_data_reg;
	logic        tx_valid_reg;
	logic        frame_error_reg;
	logic [15:0] motion_word_reg;
	logic [15:0] position_word_reg;
	logic [15:0] speed_force_reg;
	logic [1:0]  sta_reg;
	logic [15:0] rx_crc;
	logic [15:0] tx_crc;
	logic [15:0] start_addr;
	logic [15:0] quantity;
	logic [15:0] end_addr;
	logic        crc_ok;
	logic        addr_ok;
	logic        wr_ok;
	logic        rd_ok;
	logic [7:0]  status_byte;
	logic        tx_take;

	assign tx_take = tx_valid_reg && tx_ready;

	////////////////////////////////////////////////////////////////////////////////////////
	// CRC engines
	modbus_crc16 u_rx_crc (
		.sys_clk (sys_clk),
		.rst     (rst),
		.clear   (state_reg == ST_CHECK),
		.update  (state_reg == ST_RX && rx_valid),
		.data    (rx_data),
		.crc     (rx_crc)
	);

	modbus_crc16 u_tx_crc (
		.sys_clk (sys_clk),
		.rst     (rst),
		.clear   (state_reg == ST_CHECK),
		.update  (state_reg == ST_SEND && tx_take),
		.data    (tx_data_reg),
		.crc     (tx_crc)
	);

	////////////////////////////////////////////////////////////////////////////////////////
	// Request decode, looked at only in ST_CHECK
	always_comb begin
		start_addr = {rx_buf[2], rx_buf[3]};
		quantity   = {rx_buf[4], rx_buf[5]};
		end_addr   = 16'(start_addr + quantity);
		addr_ok    = rx_buf[0] == SLAVE_ADDR;
		crc_ok     = rx_crc == CRC_RESIDUE && !rx_overflow_reg
		             && rx_count_reg >= MIN_FRAME_LEN;
		wr_ok      = rx_buf[1] == FC_PRESET_MULTI && start_addr >= REG_MOTION
		             && quantity != 16'h0000 && quantity <= WRITE_QTY_MAX
		             && end_addr <= REG_MOTION + WRITE_QTY_MAX
		             && rx_buf[6] == {quantity[6:0], 1'b0}
		             && rx_count_reg == WRITE_HDR_LEN + {quantity[3:0], 1'b0};
		rd_ok      = rx_buf[1] == FC_READ_HOLD && start_addr == REG_STATUS
		             && quantity == READ_QTY && rx_count_reg == READ_FRAME_LEN;
	end

	// Status byte: object bits unused here, state field, go-to echo, activation echo
	assign status_byte = {2'b00, sta_reg, motion_word_reg[GTO_BIT], 2'b00,
	                      motion_word_reg[ACT_BIT]};

	////////////////////////////////////////////////////////////////////////////////////////
	// Sequencer
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			state_reg <= ST_RX;
		end else begin
			unique case (state_reg)
				ST_RX: begin
					if (rx_frame_end) begin
						state_reg <= ST_CHECK;
					end
				end
				ST_CHECK: begin
					if (crc_ok && addr_ok && (wr_ok || rd_ok)) begin
						state_reg <= ST_SEND;
					end else begin
						state_reg <= ST_RX;
					end
				end
				ST_SEND: begin
					if (tx_take && tx_idx_reg == tx_len_reg) begin
						state_reg <= ST_CRC_WAIT;
					end
				end
				ST_CRC_WAIT: begin
					state_reg <= ST_CRC_LO;
				end
				ST_CRC_LO: begin
					if (tx_take) begin
						state_reg <= ST_CRC_HI;
					end
				end
				ST_CRC_HI: begin
					if (tx_take) begin
						state_reg <= ST_RX;
					end
				end
			endcase
		end
	end

	////////////////////////////////////////////////////////////////////////////////////////
	// Receive buffer; bytes during a reply are dropped since the master must wait anyway
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			rx_count_reg    <= 5'h00;
			rx_overflow_reg <= 1'b0;
		end else if (state_reg == ST_CHECK) begin
			rx_count_reg    <= 5'h00;
			rx_overflow_reg <= 1'b0;
		end else if (state_reg == ST_RX && rx_valid) begin
			if (rx_count_reg < 5'(RX_DEPTH)) begin
				rx_count_reg <= rx_count_reg + 5'h01;
			end else begin
				rx_overflow_reg <= 1'b1;
			end
		end
	end

	always_ff @(posedge sys_clk) begin
		if (state_reg == ST_RX && rx_valid && rx_count_reg < 5'(RX_DEPTH)) begin
			rx_buf[rx_count_reg[3:0]] <= rx_data;
		end
	end

	// A frame that fails its CRC, length or overflow check is flagged for one cycle and otherwise ignored
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			frame_error_reg <= 1'b0;
		end else begin
			frame_error_reg <= state_reg == ST_CHECK && !crc_ok;
		end
	end

	////////////////////////////////////////////////////////////////////////////////////////
	// Command words, written only by a checked write frame
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			motion_word_reg   <= WORD_RESET;
			position_word_reg <= WORD_RESET;
			speed_force_reg   <= WORD_RESET;
		end else if (state_reg == ST_CHECK && crc_ok && addr_ok && wr_ok) begin
			for (int k = 0; k < 3; k++) begin
				if (start_addr + 16'(k) == REG_MOTION) begin
					motion_word_reg   <= {rx_buf[7 + 2 * k], rx_buf[8 + 2 * k]};
				end
				if (start_addr + 16'(k) == REG_POSITION && k < int'(quantity)) begin
					position_word_reg <= {rx_buf[7 + 2 * k], rx_buf[8 + 2 * k]};
				end
				if (start_addr + 16'(k) == REG_SPEED_FORCE && k < int'(quantity)) begin
					speed_force_reg   <= {rx_buf[7 + 2 * k], rx_buf[8 + 2 * k]};
				end
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////////////////
	// Activation state: a fresh activate starts the run, clearing it drops back to idle
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			sta_reg <= STA_IDLE;
		end else if (!motion_word_reg[ACT_BIT]) begin
			sta_reg <= STA_IDLE;
		end else if (sta_reg == STA_IDLE) begin
			sta_reg <= STA_BUSY;
		end else if (sta_reg == STA_BUSY && activation_complete) begin
			sta_reg <= STA_DONE;
		end
	end

	////////////////////////////////////////////////////////////////////////////////////////
	// Reply assembly
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			tx_len_reg <= 4'h0;
		end else if (state_reg == ST_CHECK) begin
			tx_len_reg <= wr_ok ? WRITE_REPLY_LEN : READ_REPLY_LEN;
		end
	end

	always_ff @(posedge sys_clk) begin
		if (state_reg == ST_CHECK) begin
			tx_buf[0] <= SLAVE_ADDR;
			if (wr_ok) begin
				for (int i = 1; i < 6; i++) begin
					tx_buf[i] <= rx_buf[i];
				end
			end else begin
				tx_buf[1] <= FC_READ_HOLD;
				tx_buf[2] <= READ_BYTE_COUNT;
				tx_buf[3] <= status_byte;
				tx_buf[4] <= STATUS_RESERVED;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////////////////
	// Byte sender; the CRC gets an idle cycle so the engine has taken the last byte
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			tx_data_reg  <= 8'h00;
			tx_valid_reg <= 1'b0;
			tx_idx_reg   <= 4'h0;
		end else begin
			unique case (state_reg)
				ST_CHECK: begin
					tx_idx_reg <= 4'h1;
					if (crc_ok && addr_ok && (wr_ok || rd_ok)) begin
						tx_data_reg  <= SLAVE_ADDR;
						tx_valid_reg <= 1'b1;
					end
				end
				ST_SEND: begin
					if (tx_take) begin
						if (tx_idx_reg == tx_len_reg) begin
							tx_valid_reg <= 1'b0;
						end else begin
							tx_data_reg <= tx_buf[tx_idx_reg[2:0]];
							tx_idx_reg  <= tx_idx_reg + 4'h1;
						end
					end
				end
				ST_CRC_WAIT: begin
					tx_data_reg  <= tx_crc[7:0];
					tx_valid_reg <= 1'b1;
				end
				ST_CRC_LO: begin
					if (tx_take) begin
						tx_data_reg <= tx_crc[15:8];
					end
				end
				ST_CRC_HI: begin
					if (tx_take) begin
						tx_valid_reg <= 1'b0;
					end
				end
				default: begin
					tx_valid_reg <= 1'b0;
				end
			endcase
		end
	end

	assign tx_data               = tx_data_reg;
	assign tx_valid              = tx_valid_reg;
	assign frame_error           = frame_error_reg;
	assign activate_request_bit  = motion_word_reg[ACT_BIT];
	assign goto_request_bit      = motion_word_reg[GTO_BIT];
	assign target_position_value = position_word_reg[7:0];
	assign speed_value           = speed_force_reg[15:8];
	assign force_value           = speed_force_reg[7:0];

	////////////////////////////////////////////////////////////////////////////////////////
	// Checks
	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (rst);

	sequence s_write_accept;
		state_reg == ST_CHECK && crc_ok && addr_ok && wr_ok;
	endsequence

	sequence s_read_accept;
		state_reg == ST_CHECK && crc_ok && addr_ok && rd_ok;
	endsequence

	a_write_echo_reply: assert property (
		s_write_accept |=> tx_valid && tx_data == SLAVE_ADDR && tx_len_reg == 4'h6
		                   && tx_buf[1] == 8'h10 && tx_buf[2] == $past(rx_buf[2]))
		else $error("write reply does not echo the request header");

	a_read_byte_count: assert property (
		s_read_accept |=> tx_len_reg == 4'h5 && tx_buf[2] == 8'h02 && tx_buf[4] == 8'h00
		                  && tx_buf[3] == $past(status_byte))
		else $error("read reply has wrong count or layout");

	a_status_busy: assert property (
		$rose(activate_request_bit) && !goto_request_bit |=> status_byte == 8'h11)
		else $error("status not 0x11 while activating");

	a_status_done: assert property (
		sta_reg == STA_BUSY && activation_complete && activate_request_bit
		&& !goto_request_bit ##1 activate_request_bit |-> status_byte == 8'h31)
		else $error("status not 0x31 once activated");

	a_bad_crc_ignored: assert property (
		state_reg == ST_CHECK && !crc_ok |=> frame_error && !tx_valid && state_reg == ST_RX
		                                    && $stable(motion_word_reg))
		else $error("frame with bad CRC was acted on");

	// Back-pressure may stall each byte without bound, so each step is checked on its own
	a_crc_tail: assert property (
		state_reg == ST_CRC_WAIT |=> tx_valid && tx_data == tx_crc[7:0])
		else $error("reply CRC low byte missing or wrong");

	a_crc_high_byte: assert property (
		state_reg == ST_CRC_LO && tx_valid && tx_ready |=> tx_valid && tx_data == tx_crc[15:8])
		else $error("reply CRC high byte missing or wrong");

endmodule

// [rtl/gripper_pkg.sv]
// Purpose: Shared constants, types and CRC arithmetic for the gripper command sequencer
// Assumes: Modbus RTU bytes arrive already deframed by a serial receiver outside
// Notes:   Register offsets are Modbus register numbers, not byte addresses
package gripper_pkg;

	////////////////////////////////////////////////////////////////////////////////////////
	// Frame fields
	localparam logic [7:0]  SLAVE_ADDR        = 8'h09;
	localparam logic [7:0]  FC_READ_HOLD      = 8'h03;
	localparam logic [7:0]  FC_PRESET_MULTI   = 8'h10;
	localparam logic [7:0]  READ_BYTE_COUNT   = 8'h02;
	localparam logic [7:0]  STATUS_RESERVED   = 8'h00;
	localparam logic [15:0] READ_QTY          = 16'h0001;
	localparam logic [15:0] WRITE_QTY_MAX     = 16'h0003;
	localparam logic [4:0]  MIN_FRAME_LEN     = 5'h04;
	localparam logic [4:0]  READ_FRAME_LEN    = 5'h08;
	localparam logic [4:0]  WRITE_HDR_LEN     = 5'h09;
	localparam logic [3:0]  WRITE_REPLY_LEN   = 4'h6;
	localparam logic [3:0]  READ_REPLY_LEN    = 4'h5;

	////////////////////////////////////////////////////////////////////////////////////////
	// Register map
	localparam logic [15:0] REG_MOTION        = 16'h03e8;
	localparam logic [15:0] REG_POSITION      = 16'h03e9;
	localparam logic [15:0] REG_SPEED_FORCE   = 16'h03ea;
	localparam logic [15:0] REG_STATUS        = 16'h07d0;
	localparam logic [15:0] WORD_RESET        = 16'h0000;

	// Action byte is the high byte of the motion command word
	localparam int          ACT_BIT           = 8;
	localparam int          GTO_BIT           = 11;

	////////////////////////////////////////////////////////////////////////////////////////
	// Activation state field
	localparam logic [1:0]  STA_IDLE          = 2'h0;
	localparam logic [1:0]  STA_BUSY          = 2'h1;
	localparam logic [1:0]  STA_DONE          = 2'h3;

	////////////////////////////////////////////////////////////////////////////////////////
	// Buffers and CRC
	localparam int          RX_DEPTH          = 16;
	localparam int          TX_DEPTH          = 8;
	localparam logic [15:0] CRC_INIT          = 16'hffff;
	localparam logic [15:0] CRC_POLY          = 16'ha001;
	localparam logic [15:0] CRC_RESIDUE       = 16'h0000;

	typedef enum logic [2:0] {
		ST_RX,
		ST_CHECK,
		ST_SEND,
		ST_CRC_WAIT,
		ST_CRC_LO,
		ST_CRC_HI
	} seq_state_t;

	// Reflected CRC-16 over one byte, low bit first
	function automatic logic [15:0] crc16_byte(input logic [15:0] crc, input logic [7:0] data);
		logic [15:0] c;
		c = crc ^ {8'h00, data};
		for (int i = 0; i < 8; i++) begin
			c = c[0] ? ((c >> 1) ^ CRC_POLY) : (c >> 1);
		end
		return c;
	endfunction

endpackage

// [rtl/modbus_crc16.sv]
// Purpose: Running Modbus CRC-16 over a byte stream
// Assumes: clear and update never asserted together by the caller
// Notes:   Feeding a whole frame including its CRC leaves the residue zero
`timescale 1ns/10ps
module modbus_crc16
	import gripper_pkg::*;
(
	// Clock and reset
	input  wire logic        sys_clk,
	input  wire logic        rst,
	// Stream
	input  wire logic        clear,
	input  wire logic        update,
	input  wire logic [7:0]  data,
	output logic      [15:0] crc
);

	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			crc <= CRC_INIT;
		end else if (clear) begin
			crc <= CRC_INIT;
		end else if (update) begin
			crc <= crc16_byte(crc, data);
		end
	end

endmodule

// [sim/modbus_master_model.sv]
// Purpose: Behavioural bus master that feeds request bytes and drains reply bytes
// Assumes: Bytes arrive already deframed; one request is in flight at a time
// Notes:   The inter-command gap is shortened from milliseconds to GAP cycles
`timescale 1ns/10ps
module modbus_master_model #(
	parameter int GAP = 20
) (
	// Clock
	input  wire logic       sys_clk,
	// Request bytes
	output logic            rx_valid,
	output logic      [7:0] rx_data,
	output logic            rx_frame_end,
	// Reply bytes
	input  wire logic       tx_valid,
	output logic            tx_ready
);
	int unsigned taken;
	int          seed;

	initial begin
		seed = 32'ha22f11f5;
		taken = 0;
		rx_valid = 1'b0;
		rx_data = 8'h00;
		rx_frame_end = 1'b0;
		tx_ready = 1'b0;
	end

	////////////////////////////////////////////////////////////////////////////////
	// Random stalls so the reply path sees back-pressure
	always @(posedge sys_clk) begin
		if (tx_valid && tx_ready)
			taken <= taken + 1;
		tx_ready <= ($random(seed) & 3) != 0;
	end

	////////////////////////////////////////////////////////////////////////////////
	// Whole frame out, CRC already appended by the caller
	task automatic send(input logic [7:0] frm[$], input int n_reply);
		int unsigned base;
		int          t;
		base = taken;
		foreach (frm[i]) begin
			@(posedge sys_clk);
			rx_valid <= 1'b1;
			rx_data <= frm[i];
		end
		@(posedge sys_clk);
		rx_valid <= 1'b0;
		// Released line shows the inverse, not a stale byte
		rx_data <= ~frm[frm.size() - 1];
		rx_frame_end <= 1'b1;
		@(posedge sys_clk);
		rx_frame_end <= 1'b0;
		t = 0;
		while (taken - base < n_reply && t < 400) begin
			@(posedge sys_clk);
			t++;
		end
		repeat (GAP) @(posedge sys_clk);
	endtask
endmodule

// [sim/gripper_modbus_command_sequencer_bench.sv]
// Purpose: Self-checking bench for the gripper command sequencer
// Assumes: Master model waits for each full reply before the next request
// Notes:   Reply bytes are checked from a queue of expected bytes
`timescale 1ns/10ps
module gripper_modbus_command_sequencer_bench;
	import gripper_pkg::*;

	logic       sys_clk;
	logic       rst;
	logic       rx_valid;
	logic [7:0] rx_data;
	logic       rx_frame_end;
	logic [7:0] tx_data;
	logic       tx_valid;
	logic       tx_ready;
	logic       act_done;
	logic       act_bit;
	logic       goto_bit;
	logic [7:0] target;
	logic [7:0] speed;
	logic [7:0] force_v;
	logic       frame_error;
	logic [7:0] exp_q[$];
	int         fails;
	int         cmp_count;
	int         err_seen;
	int         exp_err;
	int         cyc;
	int         seed;

	initial begin
		sys_clk = 1'b0;
		forever #2 sys_clk = ~sys_clk;
	end

	gripper_modbus_command_sequencer uut (
		.sys_clk(sys_clk), .rst(rst), .rx_valid(rx_valid), .rx_data(rx_data),
		.rx_frame_end(rx_frame_end), .tx_data(tx_data), .tx_valid(tx_valid),
		.tx_ready(tx_ready), .activation_complete(act_done),
		.activate_request_bit(act_bit), .goto_request_bit(goto_bit),
		.target_position_value(target), .speed_value(speed), .force_value(force_v),
		.frame_error(frame_error)
	);

	modbus_master_model mm (
		.sys_clk(sys_clk), .rx_valid(rx_valid), .rx_data(rx_data),
		.rx_frame_end(rx_frame_end), .tx_valid(tx_valid), .tx_ready(tx_ready)
	);

	////////////////////////////////////////////////////////////////////////////////
	task automatic mismatch(input string msg);
		fails++;
		$display("mismatch at %0t: %s", $time, msg);
	endtask

	task automatic cmp_tx(input logic [7:0] got, input logic [7:0] exp);
		cmp_count++;
		if (got !== exp)
			mismatch($sformatf("reply byte %h, expected %h", got, exp));
	endtask

	task automatic cmp_cmd(input logic [7:0] got, input logic [7:0] exp);
		cmp_count++;
		if (got !== exp)
			mismatch($sformatf("output %h, expected %h", got, exp));
	endtask

	function automatic logic [15:0] crc_of(input logic [7:0] b[$]);
		logic [15:0] c;
		c = 16'hffff;
		foreach (b[i]) begin
			c ^= {8'h00, b[i]};
			repeat (8) c = c[0] ? ((c >> 1) ^ 16'ha001) : (c >> 1);
		end
		return c;
	endfunction

	task automatic add_crc(inout logic [7:0] b[$]);
		logic [15:0] c;
		c = crc_of(b);
		b.push_back(c[7:0]);
		b.push_back(c[15:8]);
	endtask

	// Three-word write from the motion word; bad corrupts the CRC
	task automatic wr3(input logic [15:0] w0, w1, w2, input bit bad);
		logic [7:0] f[$];
		logic [7:0] e[$];
		f = '{8'h09, 8'h10, 8'h03, 8'he8, 8'h00, 8'h03, 8'h06, w0[15:8], w0[7:0],
			w1[15:8], w1[7:0], w2[15:8], w2[7:0]};
		add_crc(f);
		e = f[0:5];
		add_crc(e);
		if (bad) begin
			f[13] = f[13] ^ 8'h01;
			exp_err++;
		end else
			exp_q = {exp_q, e};
		mm.send(f, bad ? 0 : 8);
	endtask

	task automatic rd(input logic [7:0] status);
		logic [7:0] f[$];
		logic [7:0] e[$];
		f = '{8'h09, 8'h03, 8'h07, 8'hd0, 8'h00, 8'h01};
		add_crc(f);
		e = '{8'h09, 8'h03, 8'h02, status, 8'h00};
		add_crc(e);
		exp_q = {exp_q, e};
		mm.send(f, 7);
	endtask

	task automatic check_cmd(input logic [15:0] w0, w1, w2);
		#1;
		cmp_cmd({6'h00, goto_bit, act_bit}, {6'h00, w0[11], w0[8]});
		cmp_cmd(target, w1[7:0]);
		cmp_cmd(speed, w2[15:8]);
		cmp_cmd(force_v, w2[7:0]);
	endtask

	task automatic end_test(input string name);
		cmp_cmd(8'(exp_q.size()), 8'h00);
		cmp_cmd(8'(err_seen), 8'(exp_err));
		$display("test %s done, %0d mismatches so far", name, fails);
	endtask

	task automatic close_out();
		$display("counts: %0d compares, %0d mismatches", cmp_count, fails);
		if (fails == 0 && cmp_count > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask

	////////////////////////////////////////////////////////////////////////////////
	// Reply watcher and timeout
	always @(posedge sys_clk) begin
		cyc <= cyc + 1;
		if (cyc == 30000) begin
			mismatch("timeout");
			close_out();
		end
		if (!rst) begin
			if (frame_error === 1'b1)
				err_seen <= err_seen + 1;
			if (tx_valid === 1'b1 && tx_ready === 1'b1) begin
				if (exp_q.size() == 0)
					mismatch($sformatf("unexpected reply byte %h", tx_data));
				else
					cmp_tx(tx_data, exp_q.pop_front());
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	initial begin
		logic [15:0] w1;
		logic [15:0] w2;
		fails = 0;
		cmp_count = 0;
		err_seen = 0;
		exp_err = 0;
		cyc = 0;
		seed = 32'ha22f11f5;
		rst = 1'b1;
		act_done = 1'b0;
		repeat (2) @(posedge sys_clk);
		rst <= 1'b0;
		@(posedge sys_clk);
		check_cmd(16'h0000, 16'h0000, 16'h0000);
		rd(8'h00);
		end_test("reset");
		wr3(16'h0000, 16'h0000, 16'h0000, 1'b0);
		wr3(16'h0100, 16'h0000, 16'h0000, 1'b0);
		check_cmd(16'h0100, 16'h0000, 16'h0000);
		rd(8'h11);
		rd(8'h11);
		act_done <= 1'b1;
		rd(8'h31);
		end_test("activation");
		wr3(16'h0900, 16'h00ff, 16'hffff, 1'b0);
		check_cmd(16'h0900, 16'h00ff, 16'hffff);
		rd(8'h39);
		end_test("close");
		repeat (4) begin
			w1 = {8'h00, 8'($random(seed))};
			w2 = 16'($random(seed));
			wr3(16'h0900, w1, w2, 1'b0);
			check_cmd(16'h0900, w1, w2);
		end
		end_test("random");
		wr3(16'h0000, 16'h0011, 16'h2233, 1'b1);
		check_cmd(16'h0900, w1, w2);
		end_test("bad crc");
		close_out();
	end
endmodule
